// File: pkg/ddrmr_consts.svh
// Constants for the mode-register configuration block: command and field positions.
// Assumes the SDRAM clock is the only clock and all pins are sampled on it.
`ifndef DDRMR_CONSTS_SVH
`define DDRMR_CONSTS_SVH
`define DDRMR_BA_MR0 3'h0
`define DDRMR_BA_MR1 3'h1
`define DDRMR_A_PPD 12
`define DDRMR_A_DLLRST 8
`define DDRMR_A_TEST 7
`define DDRMR_A_DLLOFF 0
`define DDRMR_A_WLVL 7
`define DDRMR_A_TSTRB 11
`define DDRMR_A_QOFF 12
`define DDRMR_A_AUTOPRE 10
`define DDRMR_A_CHOP 12
`define DDRMR_BL_FIXED8 2'h0
`define DDRMR_BL_OTF 2'h1
`define DDRMR_BL_FIXED4 2'h2
`define DDRMR_BURST8_CLKS 3'h4
`define DDRMR_BURST4_CLKS 3'h2
`define DDRMR_CLK_NS 100
`define DDRMR_TDLLK_CYC 512
`define DDRMR_TRP_NS 15
`define DDRMR_TXP_NS 6
`define DDRMR_TXPDLL_NS 24
`define DDRMR_PIPE_DEPTH 32
`endif

// File: pkg/ddrmr_pkg.sv
// Types shared by the mode-register configuration block.
// Assumes ddrmr_consts.svh supplies the numeric constants.
package ddrmr_pkg;
  typedef enum logic [3:0] {
    DLL_OFF     = 4'b0001,
    DLL_LOCKING = 4'b0010,
    DLL_LOCKED  = 4'b0100,
    DLL_FROZEN  = 4'b1000
  } ddrmr_dll_e;
  typedef logic [14:0] ddrmr_addr_t;
endpackage

// File: src/ddrmr_delay_line.sv
// Tapped delay line: outData_r follows inData by delaySel+1 clocks.
// Assumes the tap select stays put while an entry travels through.
module ddrmr_delay_line
  import ddrmr_pkg::*;
#(
  parameter int W = 2,
  parameter int DEPTH = 32
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] inData,
  input wire logic [$clog2(DEPTH)-1:0] delaySel,
  output logic [W-1:0] outData_r
);
  logic [W-1:0] stage_r [DEPTH];
  logic [W-1:0] stage_nxt [DEPTH];

  always_comb begin
    stage_nxt[0] = inData;
    for (int i = 1; i < DEPTH; i++) begin
      stage_nxt[i] = stage_r[i-1];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        stage_r[i] <= '0;
      end
      outData_r <= '0;
    end else begin
      stage_r <= stage_nxt;
      outData_r <= stage_nxt[delaySel];
    end
  end
endmodule

// File: src/ddrmr_mode_config.sv
// Mode-register configuration of the SDRAM: latency, DLL and driver setup.
// Assumes command pins are synchronous to sys_clk; CWL comes from elsewhere.
// What this block does
// - Read data starts AL plus CL clocks later
// - Test-mode bit captured; controller keeps it zero
// - DLL reset bit clears itself after use
// - Write recovery plus precharge forms write-to-activate
// - Fixed chop-4 pulls write recovery two clocks earlier
// - Power-down exit delay follows DLL exit select
// - Second register written on bank address one
// - Drive impedance from address bits 5 and 1
// - Nominal termination from address bits 9,6,2
// - Additive latency zero, CL-1 or CL-2
// - Command held additive latency before internal issue
// - Output-off bit disconnects the data outputs
// - Address bit 7 enables write leveling
// - DLL frozen in self-refresh, restarts on exit
// - Write termination needs a running DLL
// - CAS latency code on address bits 6,5,4,2
`include "ddrmr_consts.svh"
module ddrmr_mode_config
  import ddrmr_pkg::*;
#(
  parameter int TDLLK_CYC = `DDRMR_TDLLK_CYC,
  parameter int TRP_NS = `DDRMR_TRP_NS,
  parameter int TXP_NS = `DDRMR_TXP_NS,
  parameter int TXPDLL_NS = `DDRMR_TXPDLL_NS
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic cke,
  input wire logic csN,
  input wire logic rasN,
  input wire logic casN,
  input wire logic weN,
  input wire logic [2:0] ba,
  input wire ddrmr_addr_t addr,
  input wire logic [3:0] cwlCycles,
  input wire logic writeTermEn,
  output logic [3:0] clCycles_r,
  output logic [3:0] alCycles_r,
  output logic [4:0] readLatency_r,
  output logic [3:0] wrCycles_r,
  output logic [1:0] burstMode_r,
  output logic testMode_r,
  output logic dllResetReq_r,
  output logic ppdFastExit_r,
  output logic [7:0] pdExitCycles_r,
  output logic dllEnabled_r,
  output logic [1:0] driveSel_r,
  output logic [2:0] rttNomSel_r,
  output logic writeLevel_r,
  output logic termStrobeEn_r,
  output logic outputOff_r,
  output logic reservedCode_r,
  output logic dllLocked_r,
  output logic wrTermDllMissing_r,
  output logic readDataStart_r,
  output logic dqOutEnable_r,
  output logic wrRecoveryStart_r,
  output logic dalBusy_r
);
  // Least times round up to whole clocks, never below one
  localparam int TRP_CYC = (TRP_NS + `DDRMR_CLK_NS - 1) / `DDRMR_CLK_NS;
  localparam int TXP_CYC = (TXP_NS + `DDRMR_CLK_NS - 1) / `DDRMR_CLK_NS;
  localparam int TXPDLL_CYC = (TXPDLL_NS + `DDRMR_CLK_NS - 1) / `DDRMR_CLK_NS;
  localparam logic [7:0] TRP8 = 8'(TRP_CYC < 1 ? 1 : TRP_CYC);
  localparam logic [7:0] TXP8 = 8'(TXP_CYC < 1 ? 1 : TXP_CYC);
  localparam logic [7:0] TXPDLL8 = 8'(TXPDLL_CYC < 1 ? 1 : TXPDLL_CYC);
  localparam int LW = $clog2(TDLLK_CYC + 1);
  localparam logic [LW-1:0] TDLLK_W = LW'(TDLLK_CYC);

  logic cmdMrs, mr0Wr, mr1Wr, cmdRd, cmdWr, srEnter, dllRstWr;
  logic [1:0] alCode_r, alCode_nxt;
  logic [3:0] cl_nxt, al_nxt, wr_nxt;
  logic [1:0] burst_nxt, drive_nxt;
  logic [2:0] rtt_nxt;
  logic test_nxt, ppd_nxt, dllEn_nxt, wlvl_nxt, tstrb_nxt, qoff_nxt, resv_nxt;
  logic rdChop, wrChop;
  logic [1:0] rdOut, wrOut;
  logic [5:0] wrDelay;
  logic [4:0] wrSel;

  assign cmdMrs = cke & ~csN & ~rasN & ~casN & ~weN;
  assign mr0Wr = cmdMrs & (ba == `DDRMR_BA_MR0);
  assign mr1Wr = cmdMrs & (ba == `DDRMR_BA_MR1);
  assign cmdRd = ~csN & rasN & ~casN & weN;
  assign cmdWr = ~csN & rasN & ~casN & ~weN;
  assign srEnter = ~csN & ~rasN & ~casN & weN & ~cke;
  assign dllRstWr = mr0Wr & addr[`DDRMR_A_DLLRST];
  // Chop-4 on the fly is selected by a low chop pin on reads; writes chop only in fixed chop-4 mode
  assign rdChop = (burstMode_r == `DDRMR_BL_FIXED4) |
                  ((burstMode_r == `DDRMR_BL_OTF) & ~addr[`DDRMR_A_CHOP]);
  assign wrChop = (burstMode_r == `DDRMR_BL_FIXED4);

  // Mode fields; decode of the latency codes is registered with them
  always_comb begin
    logic [3:0] clc;
    clc = {addr[6], addr[5], addr[4], addr[2]};
    {cl_nxt, wr_nxt, burst_nxt, test_nxt, ppd_nxt} =
      {clCycles_r, wrCycles_r, burstMode_r, testMode_r, ppdFastExit_r};
    {alCode_nxt, drive_nxt, rtt_nxt} = {alCode_r, driveSel_r, rttNomSel_r};
    {dllEn_nxt, wlvl_nxt, tstrb_nxt, qoff_nxt} =
      {dllEnabled_r, writeLevel_r, termStrobeEn_r, outputOff_r};
    resv_nxt = reservedCode_r;
    if (mr0Wr) begin
      unique case (clc)
        4'h2: cl_nxt = 4'h5;
        4'h4: cl_nxt = 4'h6;
        4'h6: cl_nxt = 4'h7;
        4'h8: cl_nxt = 4'h8;
        4'ha: cl_nxt = 4'h9;
        4'hc: cl_nxt = 4'ha;
        4'he: cl_nxt = 4'hb;
        4'h1: cl_nxt = 4'hc;
        4'h3: cl_nxt = 4'hd;
        4'h5: cl_nxt = 4'he;
        default: cl_nxt = 4'h0;
      endcase
      unique case (addr[11:9])
        3'h1: wr_nxt = 4'h5;
        3'h2: wr_nxt = 4'h6;
        3'h3: wr_nxt = 4'h7;
        3'h4: wr_nxt = 4'h8;
        3'h5: wr_nxt = 4'ha;
        3'h6: wr_nxt = 4'hc;
        3'h7: wr_nxt = 4'he;
        default: wr_nxt = 4'h0;
      endcase
      burst_nxt = addr[1:0];
      test_nxt = addr[`DDRMR_A_TEST];
      ppd_nxt = addr[`DDRMR_A_PPD];
    end
    if (mr1Wr) begin
      dllEn_nxt = ~addr[`DDRMR_A_DLLOFF];
      drive_nxt = {addr[5], addr[1]};
      rtt_nxt = {addr[9], addr[6], addr[2]};
      alCode_nxt = addr[4:3];
      wlvl_nxt = addr[`DDRMR_A_WLVL];
      tstrb_nxt = addr[`DDRMR_A_TSTRB];
      qoff_nxt = addr[`DDRMR_A_QOFF];
    end
    unique case (alCode_nxt)
      2'h1: al_nxt = cl_nxt - 4'h1;
      2'h2: al_nxt = cl_nxt - 4'h2;
      default: al_nxt = 4'h0;
    endcase
    // Reserved CL and WR codes store zero, the other reserved codes are stored as given; all are flagged
    if (mr0Wr | mr1Wr) begin
      resv_nxt = (cl_nxt == 4'h0) | (wr_nxt == 4'h0) | (burst_nxt == 2'h3) |
                 drive_nxt[1] | (rtt_nxt[2:1] == 2'h3) | (alCode_nxt == 2'h3);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      {clCycles_r, alCycles_r, wrCycles_r, alCode_r, burstMode_r} <= '0;
      {testMode_r, ppdFastExit_r, dllEnabled_r, driveSel_r, rttNomSel_r} <= '0;
      {writeLevel_r, termStrobeEn_r, outputOff_r, reservedCode_r} <= '0;
      readLatency_r <= 5'h0;
      pdExitCycles_r <= TXPDLL8;
    end else begin
      {clCycles_r, alCycles_r, wrCycles_r, alCode_r} <= {cl_nxt, al_nxt, wr_nxt, alCode_nxt};
      {burstMode_r, testMode_r, ppdFastExit_r} <= {burst_nxt, test_nxt, ppd_nxt};
      {dllEnabled_r, driveSel_r, rttNomSel_r} <= {dllEn_nxt, drive_nxt, rtt_nxt};
      {writeLevel_r, termStrobeEn_r, outputOff_r} <= {wlvl_nxt, tstrb_nxt, qoff_nxt};
      reservedCode_r <= resv_nxt;
      readLatency_r <= {1'b0, al_nxt} + {1'b0, cl_nxt};
      pdExitCycles_r <= ppd_nxt ? TXP8 : TXPDLL8;
    end
  end

  // DLL: reset request, lock count, freeze in self-refresh
  ddrmr_dll_e dllState_r, dllState_nxt;
  logic [LW-1:0] lockCnt_r, lockCnt_nxt;
  logic srActive_r, srActive_nxt, dllReq_nxt, locked_nxt, termMiss_nxt;

  always_comb begin
    dllState_nxt = dllState_r;
    lockCnt_nxt = lockCnt_r;
    srActive_nxt = srActive_r;
    if (srEnter) begin
      srActive_nxt = 1'b1;
    end else if (cke) begin
      srActive_nxt = 1'b0;
    end
    // Bit reads one for a single clock, then drops without a rewrite
    dllReq_nxt = dllRstWr;
    unique case (dllState_r)
      DLL_OFF: begin
        if (dllEn_nxt) begin
          dllState_nxt = DLL_LOCKING;
          lockCnt_nxt = TDLLK_W;
        end
      end
      DLL_LOCKING, DLL_LOCKED: begin
        if (!dllEn_nxt) begin
          dllState_nxt = DLL_OFF;
        end else if (srActive_nxt | (~cke & ~ppd_nxt)) begin
          dllState_nxt = DLL_FROZEN;
        end else if (dllResetReq_r) begin
          dllState_nxt = DLL_LOCKING;
          lockCnt_nxt = TDLLK_W;
        end else if (dllState_r == DLL_LOCKING) begin
          lockCnt_nxt = lockCnt_r - LW'(1);
          if (lockCnt_r <= LW'(1)) begin
            dllState_nxt = DLL_LOCKED;
          end
        end
      end
      DLL_FROZEN: begin
        if (!dllEn_nxt) begin
          dllState_nxt = DLL_OFF;
        end else if (cke) begin
          // Self-refresh exit relocks; slow power-down exit keeps the lock
          dllState_nxt = srActive_r ? DLL_LOCKING : DLL_LOCKED;
          lockCnt_nxt = TDLLK_W;
        end
      end
    endcase
    locked_nxt = (dllState_nxt == DLL_LOCKED);
    termMiss_nxt = writeTermEn & ~locked_nxt & (dllState_nxt != DLL_LOCKING);
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      dllState_r <= DLL_OFF;
      lockCnt_r <= '0;
      {srActive_r, dllResetReq_r, dllLocked_r, wrTermDllMissing_r} <= '0;
    end else begin
      dllState_r <= dllState_nxt;
      lockCnt_r <= lockCnt_nxt;
      {srActive_r, dllResetReq_r} <= {srActive_nxt, dllReq_nxt};
      {dllLocked_r, wrTermDllMissing_r} <= {locked_nxt, termMiss_nxt};
    end
  end

  // Read and write pipes; additive latency is part of each delay
  ddrmr_delay_line #(.W(2), .DEPTH(`DDRMR_PIPE_DEPTH)) u_rdPipe (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .inData({rdChop, cmdRd}),
    .delaySel(readLatency_r - 5'h1),
    .outData_r(rdOut)
  );
  // Recovery starts at burst end; fixed chop-4 ends two clocks earlier
  assign wrDelay = {2'b0, alCycles_r} + {2'b0, cwlCycles} +
                   (wrChop ? {3'b0, `DDRMR_BURST4_CLKS} : {3'b0, `DDRMR_BURST8_CLKS});
  assign wrSel = (wrDelay > 6'h20) ? 5'h1f : 5'(wrDelay - 6'h1);
  ddrmr_delay_line #(.W(2), .DEPTH(`DDRMR_PIPE_DEPTH)) u_wrPipe (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .inData({addr[`DDRMR_A_AUTOPRE], cmdWr}),
    .delaySel(wrSel),
    .outData_r(wrOut)
  );

  logic [2:0] burstLeft_r, burstLeft_nxt;
  logic [7:0] dalCnt_r, dalCnt_nxt;
  logic dqEn_nxt;
  always_comb begin
    burstLeft_nxt = (burstLeft_r != 3'h0) ? burstLeft_r - 3'h1 : 3'h0;
    if (rdOut[0]) begin
      burstLeft_nxt = rdOut[1] ? `DDRMR_BURST4_CLKS : `DDRMR_BURST8_CLKS;
    end
    dqEn_nxt = (burstLeft_nxt != 3'h0) & ~qoff_nxt;
    dalCnt_nxt = (dalCnt_r != 8'h0) ? dalCnt_r - 8'h1 : 8'h0;
    if (wrOut[0] & wrOut[1]) begin
      dalCnt_nxt = {4'h0, wrCycles_r} + TRP8;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      burstLeft_r <= 3'h0;
      dalCnt_r <= 8'h0;
      {readDataStart_r, dqOutEnable_r, wrRecoveryStart_r, dalBusy_r} <= '0;
    end else begin
      burstLeft_r <= burstLeft_nxt;
      dalCnt_r <= dalCnt_nxt;
      readDataStart_r <= rdOut[0];
      dqOutEnable_r <= dqEn_nxt;
      wrRecoveryStart_r <= wrOut[0];
      dalBusy_r <= (dalCnt_nxt != 8'h0);
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  sequence s_rstWrite;
    dllRstWr ##1 !dllRstWr;
  endsequence
  sequence s_selfClear;
    dllResetReq_r ##1 !dllResetReq_r;
  endsequence
  property p_dllSelfClear;
    s_rstWrite |-> s_selfClear;
  endproperty
  a_dllSelfClear: assert property (p_dllSelfClear) else $error("DLL reset bit stuck");
  property p_testMode;
    mr0Wr |=> testMode_r == $past(addr[7]);
  endproperty
  a_testMode: assert property (p_testMode) else $error("Test bit not captured");
  property p_drive;
    mr1Wr |=> driveSel_r == {$past(addr[5]), $past(addr[1])};
  endproperty
  a_drive: assert property (p_drive) else $error("Drive select wrong");
  property p_rttNom;
    mr1Wr |=> rttNomSel_r == {$past(addr[9]), $past(addr[6]), $past(addr[2])};
  endproperty
  a_rttNom: assert property (p_rttNom) else $error("Termination select wrong");
  property p_alMinusOne;
    alCode_r == 2'h1 |-> alCycles_r == clCycles_r - 4'h1;
  endproperty
  a_alMinusOne: assert property (p_alMinusOne) else $error("Additive latency wrong");
  property p_readLat5;
    // The start flag is set on the fifth edge, so it is sampled high on the sixth
    cmdRd && readLatency_r == 5'h5 ##1 $stable(readLatency_r) [*5] |=> readDataStart_r;
  endproperty
  a_readLat5: assert property (p_readLat5) else $error("Read data late or early");
  property p_qoff;
    outputOff_r |-> !dqOutEnable_r;
  endproperty
  a_qoff: assert property (p_qoff) else $error("Outputs driven while off");
  property p_ppd;
    mr0Wr && addr[12] |=> pdExitCycles_r == TXP8;
  endproperty
  a_ppd: assert property (p_ppd) else $error("Fast exit delay wrong");
  property p_srFreeze;
    srActive_r |-> !dllLocked_r;
  endproperty
  a_srFreeze: assert property (p_srFreeze) else $error("DLL runs in self-refresh");
  property p_dal;
    wrOut[0] && wrOut[1] && wrCycles_r != 4'h0 |=> dalBusy_r [*5];
  endproperty
  a_dal: assert property (p_dal) else $error("Write-to-activate too short");
endmodule

// File: dv/ddrmr_ctrl_model.sv
// Memory controller model that issues commands on the SDRAM command pins.
// Assumes the bench calls issue(); each command is taken on the edge where issue returns.
`include "ddrmr_consts.svh"
module ddrmr_ctrl_model
  import ddrmr_pkg::*;
(
  input wire logic sys_clk,
  output logic cke,
  output logic csN,
  output logic rasN,
  output logic casN,
  output logic weN,
  output logic [2:0] ba,
  output ddrmr_addr_t addr
);
  timeunit 1ns;
  timeprecision 1ns;
  // Clock enable stays high except in self-refresh, so lock waits see it high
  initial begin
    cke = 1'b1;
    {csN, rasN, casN, weN} = 4'hf;
    ba = 3'h0;
    addr = '0;
  end
  // Kind: 0 mode set, 1 read, 2 write, 3 self-refresh entry, 4 self-refresh exit
  task automatic issue(input logic [2:0] kind, input logic [2:0] bank, input ddrmr_addr_t a);
    ddrmr_addr_t m;
    m = a;
    if (kind == 3'h0 && bank == `DDRMR_BA_MR1) begin
      m = a & 15'h12ff;
    end
    if (kind == 3'h0 && bank == `DDRMR_BA_MR0) begin
      m = a & 15'h1f7f;
    end
    @(posedge sys_clk);
    csN <= (kind == 3'h4);
    rasN <= !(kind == 3'h0 || kind == 3'h3);
    casN <= (kind == 3'h4);
    weN <= !(kind == 3'h0 || kind == 3'h2);
    cke <= (kind != 3'h3);
    ba <= bank;
    addr <= m;
    @(posedge sys_clk);
    // Deselected pins wander so that no stale value can be mistaken for a command
    {csN, rasN, casN, weN} <= 4'hf;
    ba <= ~bank;
    addr <= ~m;
  endtask
endmodule

// File: dv/tb_ddrmr_mode_config.sv
// Self-checking bench for the mode-register configuration block.
// Assumes the controller model drives the command pins; counts are shortened.
module tb_ddrmr_mode_config
  import ddrmr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk, sys_rst, writeTermEn, cke, csN, rasN, casN, weN;
  logic [3:0] cwlCycles, clCycles_r, alCycles_r, wrCycles_r;
  logic [2:0] ba, rttNomSel_r;
  ddrmr_addr_t addr;
  logic [4:0] readLatency_r;
  logic [1:0] burstMode_r, driveSel_r;
  logic [7:0] pdExitCycles_r;
  logic testMode_r, dllResetReq_r, ppdFastExit_r, dllEnabled_r, writeLevel_r;
  logic termStrobeEn_r, outputOff_r, reservedCode_r, dllLocked_r, wrTermDllMissing_r;
  logic readDataStart_r, dqOutEnable_r, wrRecoveryStart_r, dalBusy_r;
  int error_cnt, cmp_count, n;

  ddrmr_ctrl_model ctrl (.sys_clk, .cke, .csN, .rasN, .casN, .weN, .ba, .addr);
  ddrmr_mode_config #(.TDLLK_CYC(8), .TRP_NS(100), .TXP_NS(150), .TXPDLL_NS(450)) uut (
    .sys_clk, .sys_rst, .cke, .csN, .rasN, .casN, .weN, .ba, .addr, .cwlCycles,
    .writeTermEn, .clCycles_r, .alCycles_r, .readLatency_r, .wrCycles_r, .burstMode_r,
    .testMode_r, .dllResetReq_r, .ppdFastExit_r, .pdExitCycles_r, .dllEnabled_r,
    .driveSel_r, .rttNomSel_r, .writeLevel_r, .termStrobeEn_r, .outputOff_r,
    .reservedCode_r, .dllLocked_r, .wrTermDllMissing_r, .readDataStart_r, .dqOutEnable_r,
    .wrRecoveryStart_r, .dalBusy_r);

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask

  function automatic logic sig(input int s);
    case (s)
      0: return readDataStart_r;
      1: return wrRecoveryStart_r;
      2: return dllLocked_r;
      3: return dqOutEnable_r;
      default: return dalBusy_r;
    endcase
  endfunction

  // Edges from the issuing edge until the signal is seen high
  task automatic waitSig(input int s, input int lim, output int k);
    k = 0;
    do begin
      tick();
      k++;
    end while (sig(s) !== 1'b1 && k < lim);
    if (sig(s) !== 1'b1) begin
      chk(sig(s), 1'b1);
      end_of_test();
    end
  endtask

  task automatic highLen(input int s, output int k);
    k = 0;
    while (sig(s) === 1'b1 && k < 64) begin
      k++;
      tick();
    end
  endtask

  function automatic ddrmr_addr_t mr0(input logic powerdown_dll_exit_select, input logic [2:0] wr, input logic rst,
                                      input logic [3:0] cl, input logic [1:0] bl);
    return {2'h0, powerdown_dll_exit_select, wr, rst, 1'b0, cl[3:1], 1'b0, cl[0], bl};
  endfunction

  function automatic ddrmr_addr_t mr1(input logic qoff, input logic [2:0] rtt, input logic wl,
                                      input logic [1:0] drv, input logic [1:0] al, input logic off);
    return {2'h0, qoff, 2'h0, rtt[2], 1'b0, wl, rtt[1], drv[1], al, rtt[0], drv[0], off};
  endfunction

  function automatic int expCl(input logic [3:0] c);
    if (!c[0]) return (c[3:1] == 3'h0) ? 0 : 4 + c[3:1];
    return (c[3:1] <= 3'h2) ? 12 + c[3:1] : 0;
  endfunction

  function automatic int expWr(input logic [2:0] w);
    return (w == 3'h0) ? 0 : (w <= 3'h4) ? 4 + w : 2 * w;
  endfunction

  task automatic t_reset();
    chk(clCycles_r, 0);
    chk(dllEnabled_r, 0);
    chk(pdExitCycles_r, 5);
  endtask

  task automatic t_mr0();
    for (int i = 0; i < 16; i++) begin
      ctrl.issue(3'h0, 3'h0, mr0(i[0], i[2:0], 1'b0, i[3:0], 2'h0));
      tick();
      chk(clCycles_r, expCl(i[3:0]));
      chk(wrCycles_r, expWr(i[2:0]));
      chk(reservedCode_r, expCl(i[3:0]) == 0 || expWr(i[2:0]) == 0);
      chk(pdExitCycles_r, i[0] ? 2 : 5);
      chk(ppdFastExit_r, i[0]);
      chk(testMode_r, 0);
    end
    ctrl.issue(3'h0, 3'h0, mr0(1'b1, 3'h1, 1'b1, 4'h2, 2'h0));
    // The reset bit stands for the single clock after the write
    #1;
    chk(dllResetReq_r, 1);
    tick();
    chk(dllResetReq_r, 0);
  endtask

  task automatic t_mr1();
    int al;
    ctrl.issue(3'h0, 3'h0, mr0(1'b1, 3'h1, 1'b0, 4'h4, 2'h0));
    for (int i = 0; i < 8; i++) begin
      // DLL off only with termination off; no leveling with outputs on at RZQ/8
      ctrl.issue(3'h0, 3'h1, mr1(i[1], i[2:0], i[0] && i != 5, i[1:0], i[1:0], i == 0));
      tick();
      al = (i[1:0] == 2'h0 || i[1:0] == 2'h3) ? 0 : 6 - i[1:0];
      chk(rttNomSel_r, i);
      chk(driveSel_r, i[1:0]);
      chk(alCycles_r, al);
      chk(readLatency_r, 6 + al);
      chk(writeLevel_r, i[0] && i != 5);
      chk(outputOff_r, i[1]);
      chk(dllEnabled_r, i != 0);
      chk(termStrobeEn_r, 0);
      chk(reservedCode_r, i[1] || i >= 6);
      chk(clCycles_r, 6);
    end
    ctrl.issue(3'h0, 3'h2, 15'h7fff);
    tick();
    chk(rttNomSel_r, 7);
  endtask

  task automatic t_dll();
    ctrl.issue(3'h0, 3'h1, mr1(1'b0, 3'h0, 1'b0, 2'h0, 2'h0, 1'b1));
    tick();
    chk(wrTermDllMissing_r, 0);
    chk(dllEnabled_r, 0);
    ctrl.issue(3'h0, 3'h1, mr1(1'b0, 3'h1, 1'b0, 2'h0, 2'h0, 1'b0));
    waitSig(2, 20, n);
    chk(n >= 8 && n <= 10, 1);
    // Write termination only once the DLL runs
    @(posedge sys_clk) writeTermEn <= 1'b1;
    tick();
    chk(wrTermDllMissing_r, 0);
    ctrl.issue(3'h0, 3'h0, mr0(1'b0, 3'h1, 1'b1, 4'h2, 2'h0));
    tick();
    tick();
    chk(dllLocked_r, 0);
    waitSig(2, 20, n);
    ctrl.issue(3'h3, 3'h0, '0);
    tick();
    tick();
    chk(dllLocked_r, 0);
    chk(wrTermDllMissing_r, 1);
    ctrl.issue(3'h4, 3'h0, '0);
    waitSig(2, 20, n);
    @(posedge sys_clk) writeTermEn <= 1'b0;
  endtask

  task automatic t_read();
    ctrl.issue(3'h0, 3'h0, mr0(1'b0, 3'h1, 1'b0, 4'h2, 2'h1));
    ctrl.issue(3'h0, 3'h1, mr1(1'b0, 3'h1, 1'b0, 2'h0, 2'h0, 1'b0));
    ctrl.issue(3'h1, 3'h0, 15'h0000);
    waitSig(0, 20, n);
    chk(n, 5);
    highLen(3, n);
    chk(n, 2);
    ctrl.issue(3'h0, 3'h1, mr1(1'b0, 3'h1, 1'b0, 2'h0, 2'h1, 1'b0));
    tick();
    chk(readLatency_r, 9);
    ctrl.issue(3'h1, 3'h0, 15'h1000);
    waitSig(0, 20, n);
    chk(n, 9);
    highLen(3, n);
    chk(n, 4);
    ctrl.issue(3'h0, 3'h1, mr1(1'b1, 3'h1, 1'b0, 2'h0, 2'h1, 1'b0));
    ctrl.issue(3'h1, 3'h0, 15'h1000);
    waitSig(0, 20, n);
    chk(dqOutEnable_r, 0);
  endtask

  task automatic t_write();
    ctrl.issue(3'h0, 3'h1, mr1(1'b0, 3'h1, 1'b0, 2'h0, 2'h0, 1'b0));
    for (int b = 0; b < 3; b++) begin
      ctrl.issue(3'h0, 3'h0, mr0(1'b0, 3'h1, 1'b0, 4'h2, b[1:0]));
      ctrl.issue(3'h2, 3'h0, 15'h1400);
      waitSig(1, 40, n);
      chk(n, (b == 2) ? 7 : 9);
      chk(burstMode_r, b);
      // Busy rises with the recovery start, so counting begins on that clock
      highLen(4, n);
      chk(n, 6);
    end
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  initial begin
    sys_rst = 1'b1;
    writeTermEn = 1'b0;
    cwlCycles = 4'h5;
    error_cnt = 0;
    cmp_count = 0;
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b0;
    tick();
    t_reset();
    t_mr0();
    t_mr1();
    t_dll();
    t_read();
    t_write();
    end_of_test();
  end
endmodule
